// ==== hw/adc_consts.vh ====
// Shared constants of the pipelined sample converter
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

`define ADC_CODE_W 8
`define ADC_NIBBLE_W 4
`define ADC_IN_W 10
`define ADC_CODE_STEPS 255
`define ADC_CODE_ZERO 8'h00
`define ADC_CODE_FULL 8'hFF
`define ADC_NIBBLE_MAX 4'hF
`define ADC_COARSE_SHIFT 4
`define ADC_FINE_SHIFT 0
`define ADC_FIFO_DEPTH 16
`define ADC_FIFO_AW 4
`define ADC_MATH_W 26

`endif

// ==== hw/sample_fifo.v ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk, // System clock
    input wire rstn, // Synchronous reset, active low
    input wire ce, // Clock enable
    input wire [WIDTH-1:0] in_data, // Write data
    input wire in_valid, // Write request
    output wire in_ready, // Space available
    output reg [WIDTH-1:0] out_data, // Head word
    output wire out_valid, // Head word present
    input wire out_ready // Reader accepts head
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire [AW:0] fill;
    wire do_wr;
    wire do_rd;

    assign fill = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign do_wr = ce && in_valid && in_ready;
    assign do_rd = ce && out_valid && out_ready;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always @* begin
        out_data = mem[rd_ptr_reg[AW-1:0]];
    end

    always @(posedge clk) begin
        if (!rstn) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/nibble_quantizer.v ====
// One 4-bit quantizer step with rounding, saturation and optional Gray output
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.vh"
module nibble_quantizer #(
    parameter SHIFT = 0,
    parameter GRAY_OUT = 0
) (
    input wire signed [`ADC_MATH_W-1:0] num, // Scaled residue, x*255 minus prior part
    input wire signed [`ADC_MATH_W-1:0] span, // Top minus bottom reference
    output reg [`ADC_NIBBLE_W-1:0] level // Quantized nibble
);
    reg signed [`ADC_MATH_W+1:0] top;
    reg signed [`ADC_MATH_W+7:0] den;
    reg signed [`ADC_MATH_W+7:0] quo;
    reg [`ADC_NIBBLE_W-1:0] bin;

    always @* begin
        top = {(`ADC_MATH_W+2){1'b0}};
        den = {(`ADC_MATH_W+8){1'b0}};
        quo = {(`ADC_MATH_W+8){1'b0}};
        bin = {`ADC_NIBBLE_W{1'b0}};
        top = (num <<< 1) + span;
        den = span <<< (SHIFT + 1);
        // Collapsed references give code zero instead of dividing by zero
        if (span <= 0 || top < 0) begin
            bin = {`ADC_NIBBLE_W{1'b0}};
        end else begin
            quo = top / den;
            if (quo > `ADC_NIBBLE_MAX) begin
                bin = `ADC_NIBBLE_MAX;
            end else begin
                bin = quo[`ADC_NIBBLE_W-1:0];
            end
        end
        if (GRAY_OUT != 0) begin
            level = bin ^ (bin >> 1);
        end else begin
            level = bin;
        end
    end
endmodule
`default_nettype wire

// ==== hw/pipelined_adc_sample_interface.v ====
// Digital side of an 8-bit two-step pipelined sample converter
//
// Overview of operation
// - Each strobe cycle takes one new sample and delivers one finished word.
// - The input value is captured on every falling edge of the conversion strobe.
// - A word appears two and a half strobe cycles after its fall, changing only after a rise.
// - The data pins float while the active-low enable is high and drive while it is low.
// - Inputs below the bottom reference give all zeros and above the top give all ones.
// - The code is straight binary with one step equal to the reference span over 255.
// - A coarse 4-bit step picks the range used by a following fine 4-bit step.
// - The fine result is made in Gray code and turned into binary before joining the coarse.
// - The eight data outputs carry the code with bit seven as most significant.
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.vh"
module pipelined_adc_sample_interface #(
    parameter IN_W = `ADC_IN_W,
    parameter FIFO_DEPTH = `ADC_FIFO_DEPTH,
    parameter FIFO_AW = `ADC_FIFO_AW
) (
    input wire clk, // System clock, 100 MHz
    input wire rstn, // Synchronous reset, active low
    input wire ce, // Clock enable, freezes all state when low
    input wire conversion_strobe, // Conversion strobe, synchronous level
    input wire [IN_W-1:0] analog_in, // Input value as an unsigned level
    input wire [IN_W-1:0] ref_top, // Top reference level
    input wire [IN_W-1:0] ref_bottom, // Bottom reference level
    input wire output_enable_n, // Output enable, active low
    output reg [`ADC_CODE_W-1:0] sample_code, // Data pins, bit 7 is MSB
    output wire sample_code_oe, // High while the data pins are driven
    output wire pipe_primed, // Words now come from real samples
    output wire [`ADC_CODE_W-1:0] word_data, // Buffered word
    output wire word_valid, // Buffered word present
    input wire word_ready, // Reader takes buffered word
    output wire word_space, // Buffer can take a word
    output reg word_dropped // Sticky: a word met a full buffer
);
    // ******************************
    // Strobe edge detection
    // ******************************
    reg strobe_prev_reg;
    wire strobe_fall;
    wire strobe_rise;

    assign strobe_fall = ce && strobe_prev_reg && !conversion_strobe;
    assign strobe_rise = ce && !strobe_prev_reg && conversion_strobe;

    always @(posedge clk) begin
        if (!rstn) begin
            strobe_prev_reg <= 1'b0;
        end else if (ce) begin
            strobe_prev_reg <= conversion_strobe;
        end
    end

    // ******************************
    // Shared arithmetic
    // ******************************
    // References are read live, so a change mid-conversion corrupts that word
    wire signed [`ADC_MATH_W-1:0] span;
    assign span = $signed({{(`ADC_MATH_W-IN_W){1'b0}}, ref_top}) -
                  $signed({{(`ADC_MATH_W-IN_W){1'b0}}, ref_bottom});

    // Sized copy of the step count, so the product keeps the math width
    localparam signed [`ADC_MATH_W-1:0] CODE_STEPS = `ADC_CODE_STEPS;

    function signed [`ADC_MATH_W-1:0] scaled_offset;
        input [IN_W-1:0] level;
        input [IN_W-1:0] bottom;
        reg signed [`ADC_MATH_W-1:0] diff;
        begin
            diff = $signed({{(`ADC_MATH_W-IN_W){1'b0}}, level}) -
                   $signed({{(`ADC_MATH_W-IN_W){1'b0}}, bottom});
            scaled_offset = diff * CODE_STEPS;
        end
    endfunction

    // ******************************
    // Track and hold
    // ******************************
    reg [IN_W-1:0] hold_reg;
    reg hold_valid_reg;
    reg [IN_W-1:0] hold_next;
    reg hold_valid_next;

    always @* begin
        hold_next = hold_reg;
        hold_valid_next = hold_valid_reg;
        if (strobe_fall) begin
            hold_next = analog_in;
            hold_valid_next = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            hold_reg <= {IN_W{1'b0}};
            hold_valid_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            hold_valid_reg <= hold_valid_next;
        end
    end

    // ******************************
    // Coarse step
    // ******************************
    wire signed [`ADC_MATH_W-1:0] coarse_num;
    wire [`ADC_NIBBLE_W-1:0] coarse_level;
    reg [IN_W-1:0] stage1_sample_reg;
    reg [`ADC_NIBBLE_W-1:0] stage1_coarse_reg;
    reg stage1_valid_reg;

    assign coarse_num = scaled_offset(hold_reg, ref_bottom);

    nibble_quantizer #(
        .SHIFT(`ADC_COARSE_SHIFT),
        .GRAY_OUT(0)
    ) coarse_q (
        .num(coarse_num),
        .span(span),
        .level(coarse_level)
    );

    reg [IN_W-1:0] stage1_sample_next;
    reg [`ADC_NIBBLE_W-1:0] stage1_coarse_next;
    reg stage1_valid_next;

    always @* begin
        stage1_sample_next = stage1_sample_reg;
        stage1_coarse_next = stage1_coarse_reg;
        stage1_valid_next = stage1_valid_reg;
        if (strobe_rise) begin
            stage1_sample_next = hold_reg;
            stage1_coarse_next = coarse_level;
            stage1_valid_next = hold_valid_reg;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            stage1_sample_reg <= {IN_W{1'b0}};
            stage1_coarse_reg <= {`ADC_NIBBLE_W{1'b0}};
            stage1_valid_reg <= 1'b0;
        end else begin
            stage1_sample_reg <= stage1_sample_next;
            stage1_coarse_reg <= stage1_coarse_next;
            stage1_valid_reg <= stage1_valid_next;
        end
    end

    // ******************************
    // Fine step
    // ******************************
    // The coarse nibble removes its share of the span before the fine step
    wire signed [`ADC_MATH_W-1:0] coarse_part;
    wire signed [`ADC_MATH_W-1:0] fine_num;
    wire [`ADC_NIBBLE_W-1:0] fine_gray;
    reg [`ADC_NIBBLE_W-1:0] stage2_coarse_reg;
    reg [`ADC_NIBBLE_W-1:0] stage2_gray_reg;
    reg stage2_valid_reg;

    assign coarse_part = span * $signed({{(`ADC_MATH_W-`ADC_CODE_W){1'b0}},
                                         stage1_coarse_reg, {`ADC_NIBBLE_W{1'b0}}});
    assign fine_num = scaled_offset(stage1_sample_reg, ref_bottom) - coarse_part;

    nibble_quantizer #(
        .SHIFT(`ADC_FINE_SHIFT),
        .GRAY_OUT(1)
    ) fine_q (
        .num(fine_num),
        .span(span),
        .level(fine_gray)
    );

    reg [`ADC_NIBBLE_W-1:0] stage2_coarse_next;
    reg [`ADC_NIBBLE_W-1:0] stage2_gray_next;
    reg stage2_valid_next;

    always @* begin
        stage2_coarse_next = stage2_coarse_reg;
        stage2_gray_next = stage2_gray_reg;
        stage2_valid_next = stage2_valid_reg;
        if (strobe_rise) begin
            stage2_coarse_next = stage1_coarse_reg;
            stage2_gray_next = fine_gray;
            stage2_valid_next = stage1_valid_reg;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            stage2_coarse_reg <= {`ADC_NIBBLE_W{1'b0}};
            stage2_gray_reg <= {`ADC_NIBBLE_W{1'b0}};
            stage2_valid_reg <= 1'b0;
        end else begin
            stage2_coarse_reg <= stage2_coarse_next;
            stage2_gray_reg <= stage2_gray_next;
            stage2_valid_reg <= stage2_valid_next;
        end
    end

    // ******************************
    // Gray to binary and join
    // ******************************
    wire [`ADC_NIBBLE_W-1:0] fine_bin;
    wire [`ADC_CODE_W-1:0] joined_code;

    genvar gi;
    generate
        for (gi = 0; gi < `ADC_NIBBLE_W; gi = gi + 1) begin : g2b
            assign fine_bin[gi] = ^stage2_gray_reg[`ADC_NIBBLE_W-1:gi];
        end
    endgenerate

    assign joined_code = {stage2_coarse_reg, fine_bin};

    // ******************************
    // Output register and pins
    // ******************************
    // Third rise after the sample's fall: 2.5 strobe cycles of latency
    reg out_valid_reg;
    wire word_push;
    reg [`ADC_CODE_W-1:0] sample_code_next;
    reg out_valid_next;

    always @* begin
        sample_code_next = sample_code;
        out_valid_next = out_valid_reg;
        if (strobe_rise) begin
            sample_code_next = joined_code;
            out_valid_next = stage2_valid_reg;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            sample_code <= `ADC_CODE_ZERO;
            out_valid_reg <= 1'b0;
        end else begin
            sample_code <= sample_code_next;
            out_valid_reg <= out_valid_next;
        end
    end

    assign sample_code_oe = !output_enable_n;
    assign pipe_primed = out_valid_reg;

    // ******************************
    // Word buffer
    // ******************************
    // One push per strobe cycle; the converter cannot stall, so a full
    // buffer drops the word and flags it
    reg push_pending_reg;
    wire fifo_in_ready;
    reg push_pending_next;
    reg word_dropped_next;

    assign word_push = push_pending_reg;
    assign word_space = fifo_in_ready;

    always @* begin
        push_pending_next = push_pending_reg;
        word_dropped_next = word_dropped;
        if (ce) begin
            push_pending_next = strobe_rise && stage2_valid_reg;
            if (word_push && !fifo_in_ready) begin
                word_dropped_next = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            push_pending_reg <= 1'b0;
            word_dropped <= 1'b0;
        end else begin
            push_pending_reg <= push_pending_next;
            word_dropped <= word_dropped_next;
        end
    end

    sample_fifo #(
        .WIDTH(`ADC_CODE_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) word_buffer (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .in_data(sample_code),
        .in_valid(word_push),
        .in_ready(fifo_in_ready),
        .out_data(word_data),
        .out_valid(word_valid),
        .out_ready(word_ready)
    );
endmodule
`default_nettype wire

// ==== dv/adc_port_checker_asserts.sv ====
// Port assertions for the pipelined sample converter
`timescale 1ns/1ns
`default_nettype none
module adc_port_checker (
    input wire logic clk, // Clock
    input wire logic rstn, // Reset
    input wire logic ce, // Enable
    input wire logic conversion_strobe, // Strobe
    input wire logic output_enable_n, // Pin enable
    input wire logic [7:0] sample_code, // Pins
    input wire logic sample_code_oe, // Pin drive
    input wire logic pipe_primed, // Primed
    input wire logic [7:0] word_data, // Head
    input wire logic word_valid, // Head present
    input wire logic word_ready, // Reader
    input wire logic word_space, // Not full
    input wire logic word_dropped // Drop flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic prev_reg;
    logic rise_reg;
    // Own edge detector, so output moves can be tied to strobe rises
    always @(posedge clk) begin
        if (!rstn) begin
            prev_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else if (ce) begin
            prev_reg <= conversion_strobe;
            rise_reg <= conversion_strobe & ~prev_reg;
        end
    end
    property p_oe;
        sample_code_oe == !output_enable_n;
    endproperty
    a_oe: assert property (p_oe) else $error("pin drive wrong");
    property p_code_rise;
        $changed(sample_code) |-> rise_reg;
    endproperty
    a_code_rise: assert property (p_code_rise) else $error("code moved off a rise");
    property p_prime_rise;
        $rose(pipe_primed) |-> rise_reg;
    endproperty
    a_prime_rise: assert property (p_prime_rise) else $error("primed off a rise");
    property p_word_rise;
        $rose(word_valid) |-> $past(rise_reg);
    endproperty
    a_word_rise: assert property (p_word_rise) else $error("word without rise");
    property p_space;
        !word_valid |-> word_space;
    endproperty
    a_space: assert property (p_space) else $error("empty but full");
    property p_head;
        word_valid && !word_ready |=> word_valid && $stable(word_data);
    endproperty
    a_head: assert property (p_head) else $error("head lost");
    property p_drop_keep;
        word_dropped |=> word_dropped;
    endproperty
    a_drop_keep: assert property (p_drop_keep) else $error("drop flag cleared");
    property p_drop_full;
        $rose(word_dropped) |-> !$past(word_space) && $past(rise_reg);
    endproperty
    a_drop_full: assert property (p_drop_full) else $error("drop while not full");
endmodule
bind pipelined_adc_sample_interface adc_port_checker u_port_chk (.clk, .rstn, .ce,
    .conversion_strobe, .output_enable_n, .sample_code, .sample_code_oe, .pipe_primed,
    .word_data, .word_valid, .word_ready, .word_space, .word_dropped);
`default_nettype wire

// ==== dv/capture_side_model.sv ====
// Capture-side model: strobe source and buffer reader
`timescale 1ns/1ns
`default_nettype none
module capture_side_model (
    input wire logic clk, // Clock
    input wire logic run, // Strobe runs
    input wire logic [1:0] half, // Clocks per level
    input wire logic stall, // Hold off reading
    output logic conversion_strobe = 1'b0, // Strobe
    output logic word_ready = 1'b0 // Take words
);
    logic [1:0] cnt_reg = 2'h0;
    // Strobe parks low between frames, as a gated source would
    always @(negedge clk) begin
        word_ready <= ~stall;
        if (!run) begin
            conversion_strobe <= 1'b0;
            cnt_reg <= 2'h0;
        end else if (cnt_reg + 2'h1 >= half) begin
            conversion_strobe <= ~conversion_strobe;
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ==== dv/pipelined_adc_sample_interface_tb_top.sv ====
// Self-checking bench for the pipelined sample converter
`timescale 1ns/1ns
`default_nettype none
module pipelined_adc_sample_interface_tb_top;
    logic clk, rstn, run, stall, oe_n, prev_s;
    logic [1:0] half;
    logic [9:0] ain, rt, rb;
    wire strobe, ready, oe, primed, wvalid, wspace, dropped;
    wire [7:0] code, wdata;
    integer seed, fails, num_checks, cycles, popped, i;
    integer exp_q[$];
    integer corner[10] = '{0, 99, 100, 101, 354, 356, 608, 610, 611, 1023};
    pipelined_adc_sample_interface DUT (.clk(clk), .rstn(rstn), .ce(1'b1),
        .conversion_strobe(strobe), .analog_in(ain), .ref_top(rt), .ref_bottom(rb),
        .output_enable_n(oe_n), .sample_code(code), .sample_code_oe(oe),
        .pipe_primed(primed), .word_data(wdata), .word_valid(wvalid),
        .word_ready(ready), .word_space(wspace), .word_dropped(dropped));
    capture_side_model u_far (.clk(clk), .run(run), .half(half), .stall(stall),
        .conversion_strobe(strobe), .word_ready(ready));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic integer exp_code(input integer x, input integer b, input integer t);
        if (x < b)
            exp_code = 0;
        else if (x >= t)
            exp_code = 255;
        else
            exp_code = (2 * (x - b) * 255 + t - b) / (2 * (t - b));
    endfunction
    task automatic check(input logic ok, input string msg);
        num_checks = num_checks + 1;
        if (ok !== 1'b1) begin
            fails = fails + 1;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Value is set while the strobe is high, so the next fall takes it
    task automatic feed(input integer v);
        @(negedge clk);
        while (strobe !== 1'b1) @(negedge clk);
        ain = v[9:0];
        while (strobe === 1'b1) @(negedge clk);
    endtask
    always @(posedge clk) begin
        if (rstn && prev_s && !strobe)
            exp_q.push_back(exp_code(ain, rb, rt));
        if (rstn && wvalid === 1'b1 && ready === 1'b1) begin
            popped = popped + 1;
            if (exp_q.size() == 0)
                check(1'b0, "word without sample");
            else if (exp_q[0] < 0)
                void'(exp_q.pop_front());
            else
                check(wdata === 8'(exp_q.pop_front()), "word value");
        end
        prev_s = rstn & strobe;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            check(1'b0, "timeout");
            print_verdict();
        end
    end
    initial begin
        {fails, num_checks, cycles, popped} = '0;
        seed = 15603;
        {rstn, run, stall, prev_s, oe_n} = 5'h01;
        half = 2'h1;
        ain = 10'h000;
        rb = 10'h064;
        rt = 10'h262;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        check(primed === 1'b0 && code === 8'h00 && wvalid === 1'b0, "reset state");
        for (i = 0; i < 2; i = i + 1) begin
            @(negedge clk) oe_n = i[0];
            #1 check(oe === ~oe_n, "pin drive");
        end
        $display("reset and enable test done");
        run <= 1'b1;
        foreach (corner[k])
            feed(corner[k]);
        repeat (40) feed($random(seed) & 32'h3FF);
        check(primed === 1'b1, "pipeline primed");
        $display("corner and random test done");
        @(negedge clk);
        rt = 10'h3FF;
        rb = 10'h010;
        // Words converting across the change are discarded, not compared
        for (i = 1; i <= 3 && i <= exp_q.size(); i = i + 1)
            exp_q[exp_q.size() - i] = -1;
        repeat (30) feed($random(seed) & 32'h3FF);
        $display("reference change test done");
        half <= 2'h3;
        stall <= 1'b1;
        repeat (24) feed($random(seed) & 32'h3FF);
        check(wspace === 1'b0 && dropped === 1'b1, "full buffer");
        run <= 1'b0;
        @(negedge clk);
        popped = 0;
        stall <= 1'b0;
        repeat (40) @(negedge clk);
        check(popped == 16 && wvalid === 1'b0, "drain count");
        $display("fill and drain test done");
        print_verdict();
    end
endmodule
`default_nettype wire
